// [fprb_pkg.sv]
// Package: constants, field layout and carrier types of the floating-point register bank.
//
// Contract
// RQ1: NaN means exponent all ones, fraction non-zero.
// RQ2: Fraction top bit one marks signaling NaN.
// RQ3: Signaling NaN, invalid trap off: output quiet NaN.
// RQ4: Signaling NaN, invalid trap on: trap, keep destination.
// RQ5: Quiet NaN only: quiet NaN, no exception.
// RQ6: Default quiet NaN uses fixed encodings.
// RQ7: Denormal means exponent zero, fraction non-zero.
// RQ8: Flush bit set: denormals become zero.
// RQ9: Flush bit clear: denormals kept as is.
// RQ10: Two banks of 16; bank select swaps views.
// RQ11: Double views pair even/odd, even first.
// RQ12: Vector views are four consecutive singles.
// RQ13: Extended singles form column-ordered 4x4 matrix.
// RQ14: Status bits 31:22 read zero, written zero.
// RQ15: Transfer size selects 32 or 64 bit moves.
// RQ16: Double width mode selects arithmetic precision.
// RQ17: Software never sets size and precision together.
// RQ18: Cause, enable and flag bit positions fixed.
// RQ19: Arithmetic clears cause, then sets cause and flag.
// RQ20: Flags are sticky until software clears them.
// RQ21: Rounding select 00 nearest, 01 toward zero.
// RQ22: 32-bit transfer register for load/store system ops.
// RQ23: Reset loads status with its initial value.
package fprb_pkg;

   // ----------------------------------------------------------------
   // Status/control field layout
   // ----------------------------------------------------------------
   localparam int          ST_BANK_SELECT  = 21;
   localparam int          ST_TRANSFER_SZ  = 20;
   localparam int          ST_DOUBLE_MODE  = 19;
   localparam int          ST_DENORM_FLUSH = 18;
   localparam int          ST_CAUSE_LO     = 12;
   localparam int          ST_ENABLE_LO    = 7;
   localparam int          ST_FLAG_LO      = 2;
   localparam int          ST_ROUND_LO     = 0;
   localparam logic [31:0] ST_WRITE_MASK   = 32'h003F_FFFF;
   localparam logic [31:0] ST_RESET        = 32'h0004_0001;

   // Exception positions inside the six-bit cause vector.
   localparam int          EXC_ERROR       = 5;
   localparam int          EXC_INVALID     = 4;
   localparam logic [1:0]  RND_NEAREST     = 2'h0;
   localparam logic [1:0]  RND_ZERO        = 2'h1;

   // ----------------------------------------------------------------
   // Number formats
   // ----------------------------------------------------------------
   localparam logic [31:0] QNAN_SINGLE     = 32'h7FBF_FFFF;
   localparam logic [63:0] QNAN_DOUBLE     = 64'h7FF7_FFFF_FFFF_FFFF;
   localparam int          SGL_FRAC_W      = 23;
   localparam int          SGL_EXP_W       = 8;
   localparam int          DBL_FRAC_W      = 52;
   localparam int          DBL_EXP_W       = 11;

   // ----------------------------------------------------------------
   // Register bank geometry
   // ----------------------------------------------------------------
   localparam int          NUM_BANKS       = 2;
   localparam int          REGS_PER_BANK   = 16;
   localparam int          VEC_LEN         = 4;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      FPRB_MOVE     = 7'b000_0001,
      FPRB_ABSOLUTE = 7'b000_0010,
      FPRB_NEGATE   = 7'b000_0100,
      FPRB_ARITH    = 7'b000_1000,
      FPRB_LOAD     = 7'b001_0000,
      FPRB_TO_XFER  = 7'b010_0000,
      FPRB_FROM_XFER= 7'b100_0000
   } fprb_kind_t;

   typedef struct packed {
      fprb_kind_t  kind;
      logic [3:0]  dstIdx;
      logic        dstExt;
      logic [3:0]  srcAIdx;
      logic        srcAExt;
      logic [3:0]  srcBIdx;
      logic        useSrcB;
      logic [63:0] result;
      logic [5:0]  rawExc;
   } fprb_op_t;

   typedef struct packed {
      logic        isNan;
      logic        isSignaling;
      logic        isQuiet;
      logic        isDenorm;
      logic [63:0] flushed;
   } fprb_class_t;

endpackage

// [fprb_classify.sv]
// Module: classifies a single or double value and forms its flushed-to-zero form.
`timescale 1ns/1ps
module fprb_classify
   import fprb_pkg::*;
(
   input  wire logic                  isDouble, // Value holds a double in all 64 bits
   input  wire logic [63:0]           value,    // Single sits in bits 31:0
   output fprb_pkg::fprb_class_t      cls       // Classification result
);
   logic        expOnes;
   logic        expZero;
   logic        fracZero;
   logic        fracTop;
   logic [63:0] signedZero;

   always_comb begin
      if (isDouble) begin
         expOnes    = &value[62 -: DBL_EXP_W];
         expZero    = ~|value[62 -: DBL_EXP_W];
         fracZero   = ~|value[DBL_FRAC_W-1:0];
         fracTop    = value[DBL_FRAC_W-1];
         signedZero = {value[63], 63'h0};
      end else begin
         expOnes    = &value[30 -: SGL_EXP_W];
         expZero    = ~|value[30 -: SGL_EXP_W];
         fracZero   = ~|value[SGL_FRAC_W-1:0];
         fracTop    = value[SGL_FRAC_W-1];
         signedZero = {32'h0, value[31], 31'h0};
      end
   end

   always_comb begin
      cls.isNan       = expOnes & ~fracZero;              // [RQ1]
      cls.isSignaling = cls.isNan & fracTop;              // [RQ2]
      cls.isQuiet     = cls.isNan & ~fracTop;             // [RQ2]
      cls.isDenorm    = expZero & ~fracZero;              // [RQ7]
      cls.flushed     = cls.isDenorm ? signedZero : value; // Sign kept on flush.
   end
endmodule

// [fprb_bank.sv]
// Module: floating-point register banks, status/control and transfer register.
`timescale 1ns/1ps
module fprb_bank
   import fprb_pkg::*;
(
   input  wire logic                  clk,            // Core clock
   input  wire logic                  reset_n,        // Synchronous reset, active low
   input  wire logic                  opValid,        // Instruction issue strobe
   input  wire fprb_pkg::fprb_op_t    op,             // Instruction fields
   input  wire logic                  rdValid,        // Operand read strobe
   input  wire logic [3:0]            rdIdxA,         // Single view index, port A
   input  wire logic                  rdExtA,         // Port A uses extended views
   input  wire logic [3:0]            rdIdxB,         // Single view index, port B
   input  wire logic                  rdArith,        // Read feeds arithmetic
   input  wire logic [1:0]            rdVecSel,       // Quad number 0..3
   input  wire logic                  rdVecExt,       // Quad from extended views
   input  wire logic                  sysValid,       // System register access
   input  wire logic                  sysWrite,       // 1 load-system, 0 store-system
   input  wire logic                  sysSelStatus,   // 1 status, 0 transfer register
   input  wire logic [31:0]           sysWdata,       // Load-system data
   output logic [63:0]                rdDataA,        // Port A data
   output logic [63:0]                rdDataB,        // Port B data
   output logic [127:0]               rdVecData,      // Quad, lowest index in top word
   output logic [31:0]                sysRdata,       // Store-system data
   output logic                       sysAck,         // System access done pulse
   output logic                       opDone,         // Instruction retired pulse
   output logic                       fpTrap,         // Enabled exception pulse
   output logic [31:0]                statusCtl,      // Status/control value
   output logic [31:0]                cpuTransfer,    // Transfer register value
   output logic                       roundToZero,    // Rounding select decodes to zero
   output logic                       roundReserved   // Rounding select holds reserved code
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [31:0]  bankMem [NUM_BANKS][REGS_PER_BANK];
   logic [31:0]  status_r;
   logic [31:0]  status_nxt;
   logic [31:0]  xfer_r;

   logic         bankSel;
   logic         sizeSel;
   logic         dblMode;
   logic         flushOn;
   logic [4:0]   enables;

   assign bankSel = status_r[ST_BANK_SELECT];
   assign sizeSel = status_r[ST_TRANSFER_SZ];
   assign dblMode = status_r[ST_DOUBLE_MODE];
   assign flushOn = status_r[ST_DENORM_FLUSH];
   assign enables = status_r[ST_ENABLE_LO +: 5]; // [RQ18]

   // Extended views always look at the bank that the single views do not.
   function automatic logic [31:0] viewReg(input logic ext, input logic [3:0] idx);
      viewReg = bankMem[bankSel ^ ext][idx]; // [RQ10]
   endfunction

   // A wide view is the even register in the high word, its odd partner below.
   function automatic logic [63:0] viewRead(input logic ext, input logic [3:0] idx,
                                            input logic wide);
      if (wide)
         viewRead = {viewReg(ext, {idx[3:1], 1'b0}), viewReg(ext, {idx[3:1], 1'b1})}; // [RQ11]
      else
         viewRead = {32'h0, viewReg(ext, idx)};
   endfunction

   // ----------------------------------------------------------------
   // Classification of operands, result and read data
   // ----------------------------------------------------------------
   logic        opWide;
   logic        rdWide;
   logic [63:0] clsIn  [5];
   fprb_class_t clsOut [5];

   // Moves and loads follow the transfer size; everything else follows the precision.
   assign opWide = (op.kind inside {FPRB_MOVE, FPRB_LOAD}) ? sizeSel : dblMode; // [RQ15] [RQ16]
   assign rdWide = rdArith ? dblMode : sizeSel;                               // [RQ15] [RQ16]

   // A process rather than assigns, so a bank write re-evaluates the views read in functions.
   always_comb begin
      clsIn[0] = viewRead(op.srcAExt, op.srcAIdx, opWide);
      clsIn[1] = viewRead(1'b0, op.srcBIdx, opWide);
      clsIn[2] = op.result;
      clsIn[3] = viewRead(rdExtA, rdIdxA, rdWide);
      clsIn[4] = viewRead(1'b0, rdIdxB, rdWide);
   end

   for (genvar g = 0; g < 5; g++) begin : gen_cls
      fprb_classify u_cls (
         .isDouble (g < 3 ? opWide : rdWide),
         .value    (clsIn[g]),
         .cls      (clsOut[g])
      );
   end

   // ----------------------------------------------------------------
   // Instruction evaluation
   // ----------------------------------------------------------------
   logic        isArith;
   logic        anySig;
   logic        anyQuiet;
   logic        anyDenIn;
   logic [5:0]  opCause;
   logic        opWrite;
   logic        opTrap;
   logic [63:0] opValue;
   logic [63:0] signMask;
   logic [63:0] defaultNan;

   assign isArith    = op.kind == FPRB_ARITH;
   assign anySig     = clsOut[0].isSignaling | (op.useSrcB & clsOut[1].isSignaling);
   assign anyQuiet   = clsOut[0].isQuiet | (op.useSrcB & clsOut[1].isQuiet);
   assign anyDenIn   = clsOut[0].isDenorm | (op.useSrcB & clsOut[1].isDenorm);
   assign signMask   = opWide ? 64'h8000_0000_0000_0000 : 64'h0000_0000_8000_0000;
   assign defaultNan = opWide ? QNAN_DOUBLE : {32'h0, QNAN_SINGLE}; // [RQ6]

   always_comb begin
      opCause = 6'h00;                       // [RQ19]
      opWrite = 1'b1;
      opValue = op.result;
      unique case (op.kind)
         FPRB_MOVE:      opValue = clsIn[0];
         FPRB_ABSOLUTE:  opValue = clsIn[0] & ~signMask;
         FPRB_NEGATE:    opValue = clsIn[0] ^ signMask;
         FPRB_LOAD:      opValue = op.result;
         FPRB_TO_XFER:   opWrite = 1'b0;
         FPRB_FROM_XFER: opValue = {32'h0, xfer_r};
         FPRB_ARITH: begin
            if (anySig) begin
               opCause[EXC_INVALID] = 1'b1;   // [RQ3] [RQ4]
               opValue              = defaultNan;
            end else if (anyQuiet) begin
               opValue = defaultNan;          // [RQ5]
            end else begin
               opCause = op.rawExc;
               // An unflushed denormal input is reported as an error.
               opCause[EXC_ERROR] = op.rawExc[EXC_ERROR] | (~flushOn & anyDenIn); // [RQ9]
               opValue = flushOn ? clsOut[2].flushed : op.result;                 // [RQ8]
            end
            // An enabled exception leaves the destination untouched.
            opTrap  = |(opCause[4:0] & enables);
            opWrite = ~opTrap;                // [RQ4]
         end
         default:        opWrite = 1'b0;
      endcase
      opTrap = isArith & |(opCause[4:0] & enables);
   end

   // ----------------------------------------------------------------
   // Register bank writes
   // ----------------------------------------------------------------
   logic        dstBank;
   logic [3:0]  dstEven;

   assign dstBank = bankSel ^ op.dstExt;
   assign dstEven = {op.dstIdx[3:1], 1'b0};

   always_ff @(posedge clk) begin
      if (opValid && opWrite) begin
         if (opWide) begin
            bankMem[dstBank][dstEven]        <= opValue[63:32]; // [RQ11]
            bankMem[dstBank][dstEven | 4'h1] <= opValue[31:0];
         end else begin
            bankMem[dstBank][op.dstIdx] <= opValue[31:0];       // [RQ10]
         end
      end
   end

   // ----------------------------------------------------------------
   // Status/control register
   // ----------------------------------------------------------------
   logic swStatus;

   assign swStatus = sysValid && sysWrite && sysSelStatus;

   // A flag raised in the cycle that software clears it survives the clear.
   always_comb begin
      status_nxt = status_r;
      if (swStatus)
         status_nxt = sysWdata & ST_WRITE_MASK; // [RQ14]
      if (opValid && isArith) begin
         status_nxt[ST_CAUSE_LO +: 6] = opCause;                                  // [RQ19]
         status_nxt[ST_FLAG_LO +: 5]  = status_nxt[ST_FLAG_LO +: 5] | opCause[4:0]; // [RQ20]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         status_r <= ST_RESET; // [RQ23]
      else
         status_r <= status_nxt;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         roundToZero   <= 1'b1;
         roundReserved <= 1'b0;
      end else begin
         roundToZero   <= status_nxt[ST_ROUND_LO +: 2] == RND_ZERO;   // [RQ21]
         roundReserved <= status_nxt[ST_ROUND_LO +: 2] > RND_ZERO;    // [RQ21]
      end
   end

   assign statusCtl = status_r;

   // ----------------------------------------------------------------
   // Transfer register and system accesses
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n)
         xfer_r <= 32'h0000_0000;
      else if (sysValid && sysWrite && !sysSelStatus)
         xfer_r <= sysWdata;                   // [RQ22]
      else if (opValid && op.kind == FPRB_TO_XFER)
         xfer_r <= clsIn[0][31:0];
   end

   assign cpuTransfer = xfer_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sysRdata <= 32'h0000_0000;
         sysAck   <= 1'b0;
      end else begin
         sysAck <= sysValid;
         if (sysValid && !sysWrite)
            sysRdata <= sysSelStatus ? status_r : xfer_r; // [RQ22] [RQ14]
      end
   end

   // ----------------------------------------------------------------
   // Operand read ports
   // ----------------------------------------------------------------
   // Copies read raw data; only arithmetic operands are flushed.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdDataA   <= 64'h0;
         rdDataB   <= 64'h0;
         rdVecData <= 128'h0;
      end else if (rdValid) begin
         rdDataA <= (rdArith && flushOn) ? clsOut[3].flushed : clsIn[3]; // [RQ8] [RQ9]
         rdDataB <= (rdArith && flushOn) ? clsOut[4].flushed : clsIn[4]; // [RQ8] [RQ9]
         for (int k = 0; k < VEC_LEN; k++)
            // Extended quads are the columns of the matrix view.
            rdVecData[127 - 32*k -: 32] <= viewReg(rdVecExt, {rdVecSel, 2'(k)}); // [RQ12] [RQ13]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         opDone <= 1'b0;
         fpTrap <= 1'b0;
      end else begin
         opDone <= opValid;
         fpTrap <= opValid && opTrap; // [RQ4]
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_snan_trap;
      @(posedge clk) disable iff (!reset_n)
      opValid && isArith && anySig && enables[EXC_INVALID] |=> fpTrap && status_r[16] && status_r[6];
   endproperty
   a_snan_trap: assert property (p_snan_trap) else $error("sNaN with trap on not trapped"); // [RQ4]

   property p_snan_quiet;
      @(posedge clk) disable iff (!reset_n)
      opValid && isArith && anySig && !enables[EXC_INVALID] |=> !fpTrap && status_r[6];
   endproperty
   a_snan_quiet: assert property (p_snan_quiet) else $error("sNaN with trap off trapped"); // [RQ3]

   property p_qnan_silent;
      @(posedge clk) disable iff (!reset_n)
      opValid && isArith && !anySig && anyQuiet |=> status_r[17:12] == 6'h00 && !fpTrap;
   endproperty
   a_qnan_silent: assert property (p_qnan_silent) else $error("qNaN raised exception"); // [RQ5]

   property p_flag_sticky;
      @(posedge clk) disable iff (!reset_n)
      !swStatus |=> (status_r[6:2] & $past(status_r[6:2])) == $past(status_r[6:2]);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by hardware"); // [RQ20]

   property p_reserved_zero;
      @(posedge clk) disable iff (!reset_n)
      sysAck && $past(sysSelStatus) && !$past(sysWrite) |-> sysRdata[31:22] == 10'h000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // [RQ14]

   property p_reset_value;
      @(posedge clk) !reset_n |=> status_r == 32'h0004_0001 && roundToZero;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("status reset value wrong"); // [RQ23]

   property p_round_decode;
      @(posedge clk) disable iff (!reset_n)
      roundToZero == (status_r[1:0] == 2'b01) && roundReserved == status_r[1];
   endproperty
   a_round_decode: assert property (p_round_decode) else $error("rounding decode mismatch"); // [RQ21]

   property p_read_flush;
      @(posedge clk) disable iff (!reset_n)
      rdValid && rdArith && flushOn && clsOut[3].isDenorm
      |=> (rdDataA & ~64'h8000_0000_8000_0000) == 64'h0;
   endproperty
   a_read_flush: assert property (p_read_flush) else $error("denormal not flushed"); // [RQ8]

   property p_cause_clear;
      @(posedge clk) disable iff (!reset_n)
      opValid && isArith && !anySig && !anyQuiet && op.rawExc == 6'h00 && (flushOn || !anyDenIn)
      |=> status_r[17:12] == 6'h00;
   endproperty
   a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared"); // [RQ19]

   c_trap:   cover property (@(posedge clk) disable iff (!reset_n) fpTrap);
   c_qnan:   cover property (@(posedge clk) disable iff (!reset_n) opValid && isArith && anyQuiet);
   c_flush:  cover property (@(posedge clk) disable iff (!reset_n) rdValid && rdArith && flushOn
                                                                   && clsOut[3].isDenorm);
   c_swflag: cover property (@(posedge clk) disable iff (!reset_n) swStatus && opValid && isArith);
endmodule

// [fprb_core_model.sv]
// Core-side model: issues instructions and system register accesses.
`timescale 1ns/1ps
module fprb_core_model
   import fprb_pkg::*;
(
   input  wire logic          clk,          // Core clock
   output fprb_pkg::fprb_op_t op,           // Instruction fields
   output logic               opValid,      // Issue strobe
   output logic               sysValid,     // System access strobe
   output logic               sysWrite,     // Load-system when high
   output logic               sysSelStatus, // Status when high
   output logic [31:0]        sysWdata      // Load-system data
);
   initial begin
      op = '0;
      {opValid, sysValid, sysWrite, sysSelStatus, sysWdata} = '0;
   end
   // Released fields show the inverse, so a stale value never passes for a fresh one.
   task automatic issue(input fprb_op_t o);
      @(negedge clk);
      {opValid, op} = {1'h1, o};
      @(negedge clk);
      {opValid, op} = {1'h0, ~o};
   endtask
   // Load-system writes and store-system reads the status or transfer register.
   task automatic sys(input logic wr, input logic sel, input logic [31:0] d);
      @(negedge clk);
      {sysValid, sysWrite, sysSelStatus, sysWdata} = {1'h1, wr, sel, d};
      @(negedge clk);
      {sysValid, sysWdata} = {1'h0, ~d};
   endtask
endmodule

// [fp_register_bank_and_status_test.sv]
// Testbench: register bank, status/control and transfer register against a bench model.
`timescale 1ns/1ps
module fp_register_bank_and_status_test;
   import fprb_pkg::*;
   logic         clk, reset_n, opValid, rdValid, rdExtA, rdArith, rdVecExt, sysValid;
   logic         sysWrite, sysSelStatus, sysAck, opDone, fpTrap, roundToZero, roundReserved;
   logic [3:0]   rdIdxA, rdIdxB, sa, sb, dd;
   logic [1:0]   rdVecSel;
   logic [5:0]   x, c;
   logic [31:0]  sysWdata, sysRdata, statusCtl, cpuTransfer, st, d, a, b, r;
   logic [63:0]  rdDataA, rdDataB;
   logic [127:0] rdVecData;
   fprb_op_t     op;
   logic [31:0]  phys [2][16];
   logic [31:0]  tbl [8] = '{32'h3F80_0000, 32'hFFC0_0000, 32'h7F80_0001, 32'h0000_0010,
                             32'hFFBF_FFFF, 32'h7FFF_FFFF, 32'h8000_0000, 32'h807F_FFFF};
   fprb_kind_t   kinds [3] = '{FPRB_MOVE, FPRB_ABSOLUTE, FPRB_NEGATE};
   int           errors = 0, totalChecks = 0, seed;
   fprb_core_model core (.*);
   fprb_bank dut (.*);
   function automatic logic [31:0] vw(input logic e, input logic [3:0] i);
      return phys[st[21] ^ e][i];
   endfunction
   function automatic logic [63:0] pr(input logic e, input logic [3:0] i, input logic w);
      return w ? {vw(e, {i[3:1], 1'h0}), vw(e, {i[3:1], 1'h1})} : {32'h0000_0000, vw(e, i)};
   endfunction
   function automatic logic nan(input logic [31:0] v);
      return v[30:23] == 8'hFF && v[22:0] != 23'h0;
   endfunction
   function automatic logic den(input logic [31:0] v);
      return v[30:23] == 8'h00 && v[22:0] != 23'h0;
   endfunction
   function automatic fprb_op_t mk(fprb_kind_t k, logic [3:0] t, logic [3:0] p,
                                   logic [63:0] v, logic [5:0] e);
      return '{kind: k, dstIdx: t, dstExt: 1'h0, srcAIdx: p, srcAExt: 1'h0, srcBIdx: sb,
               useSrcB: 1'h1, result: v, rawExc: e};
   endfunction
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic ld(input logic e, input logic [3:0] i, input logic [31:0] v);
      fprb_op_t o;
      o = mk(FPRB_LOAD, i, 4'h0, {32'h0000_0000, v}, 6'h00);
      o.dstExt = e;
      core.issue(o);
      phys[st[21] ^ e][i] = v;
      chk(opDone, 1'h1);
   endtask
   task automatic wst(input logic [31:0] v);
      v[19] = v[19] & ~v[20];
      core.sys(1'h1, 1'h1, v);
      st = v & ST_WRITE_MASK;
      chk({sysAck, statusCtl}, {1'h1, st});
   endtask
   task automatic rd(input logic [3:0] p, input logic e, input logic ar, input logic [2:0] q);
      @(negedge clk);
      {rdValid, rdIdxA, rdExtA, rdIdxB, rdArith, rdVecSel, rdVecExt} = {1'h1, p, e, ~p, ar, q};
      @(negedge clk);
      rdValid = 1'h0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // The run needs about 6.5 us; the long margin only guards against a hang.
   initial begin
      #200_000;
      errors++;
      summarize();
   end
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      {reset_n, rdValid, rdIdxA, rdExtA, rdIdxB, rdArith, rdVecSel, rdVecExt} = '0;
      seed = $urandom(32'h5c08);
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset_n = 1'h1;
      st = 32'h0004_0001;
      chk({statusCtl, cpuTransfer, roundToZero, roundReserved}, {st, 32'h0, 2'h2});
      for (int k = 0; k < 4; k++) begin
         d = $urandom();
         wst({d[31:2], k[1:0]});
         chk({roundToZero, roundReserved}, {k == 1, k > 1});
         core.sys(1'h0, 1'h1, d);
         chk({sysAck, sysRdata}, {1'h1, st});
      end
      d = $urandom();
      core.sys(1'h1, 1'h0, d);
      core.sys(1'h0, 1'h0, ~d);
      chk({cpuTransfer, sysRdata}, {d, d});
      $display("test status and transfer done");
      wst(32'h0000_0000);
      for (int i = 0; i < 32; i++) begin
         ld(i[4], i[3:0], $urandom());
      end
      for (int m = 0; m < 6; m++) begin
         wst(m < 4 ? {10'h0, m[1:0], 20'h0_0000} : {10'h0, m[0], 21'h08_0000});
         for (int i = 0; i < 16; i++) begin
            rd(i[3:0], i[0], m > 3, i[2:0]);
            chk(rdDataA, pr(i[0], i[3:0], m > 3 || st[20]));
            chk(rdDataB, pr(1'h0, ~i[3:0], m > 3 || st[20]));
            chk(rdVecData, {vw(i[0], {i[2:1], 2'h0}), vw(i[0], {i[2:1], 2'h1}),
                            vw(i[0], {i[2:1], 2'h2}), vw(i[0], {i[2:1], 2'h3})});
         end
      end
      core.issue(mk(FPRB_TO_XFER, 4'h0, 4'h5, 64'h0, 6'h00));
      chk({cpuTransfer, statusCtl}, {vw(1'h0, 4'h5), st});
      $display("test register views done");
      wst(32'h0004_0000);
      core.issue(mk(FPRB_FROM_XFER, 4'h3, 4'h0, 64'h0, 6'h00));
      rd(4'h3, 1'h0, 1'h0, 3'h0);
      chk(rdDataA, {32'h0, phys[1][5]});
      for (int i = 0; i < 6; i++) begin
         ld(1'h0, 4'h1, i < 3 ? 32'h8000_0005 : 32'h7FC0_0001);
         core.issue(mk(kinds[i % 3], 4'h2, 4'h1, 64'h0, 6'h3F));
         d = vw(1'h0, 4'h1);
         phys[0][2] = i % 3 == 0 ? d : {(i % 3 == 2) & ~d[31], d[30:0]};
         rd(4'h2, 1'h0, 1'h0, 3'h0);
         chk({rdDataA, statusCtl}, {32'h0, phys[0][2], st});
         rd(4'h1, 1'h0, 1'h1, 3'h0);
         chk(rdDataA, {32'h0, den(d) ? {d[31], 31'h0} : d});
      end
      for (int i = 0; i < 8; i++) begin
         ld(1'h0, i[3:0], tbl[i]);
      end
      for (int n = 0; n < 60; n++) begin
         if (n % 10 == 0) begin
            wst($urandom() & 32'h0004_0F80);
         end
         {sa, sb, dd, x} = 18'($urandom()) & 18'h1_DFFF | 18'h0_0200;
         r = $urandom_range(1) ? tbl[$urandom_range(7)] : $urandom();
         core.issue(mk(FPRB_ARITH, dd, sa, {32'h0000_0000, r}, x));
         a = vw(1'h0, sa);
         b = vw(1'h0, sb);
         c = x | {!st[18] && (den(a) || den(b)), 5'h00};
         r = st[18] && den(r) ? {r[31], 31'h0} : r;
         if (nan(a) && a[22] || nan(b) && b[22]) begin
            {c, r} = {6'h10, 32'h7FBF_FFFF};
         end else if (nan(a) || nan(b)) begin
            {c, r} = {6'h00, 32'h7FBF_FFFF};
         end
         if (!(|(c[4:0] & st[11:7]))) begin
            phys[st[21]][dd] = r;
         end
         st[17:12] = c;
         st[6:2] = st[6:2] | c[4:0];
         chk({opDone, fpTrap, statusCtl}, {1'h1, |(c[4:0] & st[11:7]), st});
         rd(dd, 1'h0, 1'h0, 3'h0);
         chk(rdDataA, {32'h0, vw(1'h0, dd)});
      end
      wst(32'h0008_0000);
      sb = 4'h2;
      ld(1'h0, 4'h0, 32'h7FF8_0000);
      core.issue(mk(FPRB_ARITH, 4'h4, 4'h0, 64'h0, 6'h00));
      chk(statusCtl, {st[31:18], 6'h10, st[11:7], st[6:2] | 5'h10, st[1:0]});
      rd(4'h4, 1'h0, 1'h1, 3'h0);
      chk(rdDataA, 64'h7FF7_FFFF_FFFF_FFFF);
      $display("test arithmetic done");
      summarize();
   end
endmodule
